// *** logic/fbep_pkg.sv ***
package fbep_pkg;
    // Array geometry
    localparam int FBEP_ADDR_W = 15;
    localparam int FBEP_DATA_W = 32;
    localparam int FBEP_WIDX_W = 13;
    localparam int FBEP_WORDS = 8192;
    localparam int FBEP_UNITS = 16;
    // Field positions inside a byte address
    localparam int FBEP_WIDX_LSB = 2;
    localparam int FBEP_BLK_LSB = 10;
    localparam int FBEP_UNIT_LSB = 11;
    localparam int FBEP_BLK_W = 5;
    localparam int FBEP_UNIT_W = 4;
    localparam int FBEP_WOFF_W = 8;
    localparam logic [7:0] FBEP_BLK_LAST = 8'hFF;
    localparam logic [31:0] FBEP_ERASED = 32'hFFFFFFFF;
    localparam logic [31:0] FBEP_ZERO = 32'h00000000;

    typedef enum logic [1:0] {
        FBEP_SRC_FETCH,
        FBEP_SRC_DATA,
        FBEP_SRC_DEBUG
    } fbep_src_e;

    typedef enum logic [1:0] {
        FBEP_OP_READ,
        FBEP_OP_PROG,
        FBEP_OP_ERASE
    } fbep_op_e;

    typedef enum logic [1:0] {
        FBEP_AC_NONE,
        FBEP_AC_READ,
        FBEP_AC_PROG,
        FBEP_AC_ERASE
    } fbep_acmd_e;
endpackage

// *** logic/fbep_arr_if.sv ***
`timescale 1ns/1ps
interface fbep_arr_if;
    import fbep_pkg::*;
    fbep_acmd_e cmd;
    logic [FBEP_WIDX_W-1:0] widx;
    logic [FBEP_DATA_W-1:0] wdata;
    logic [FBEP_DATA_W-1:0] rdata;
    modport gate (output cmd, output widx, output wdata, input rdata);
    modport array (input cmd, input widx, input wdata, output rdata);
endinterface

// *** logic/fbep_array.sv ***
`timescale 1ns/1ps
module fbep_array
    import fbep_pkg::*;
(
    input wire logic clk,         // System clock
    input wire logic ce,          // Clock enable
    fbep_arr_if.array arr         // Command port from the gate
);
    logic [FBEP_DATA_W-1:0] mem [0:FBEP_WORDS-1];
    logic [FBEP_DATA_W-1:0] rdata_reg;

    assign arr.rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Programming only clears bits, as real flash cells do; only an erase
    // brings a word back to ones. No reset: contents survive rst.
    always_ff @(posedge clk) begin
        if (ce) begin
            case (arr.cmd)
                FBEP_AC_READ: begin
                    rdata_reg <= mem[arr.widx];
                end
                FBEP_AC_PROG: begin
                    mem[arr.widx] <= mem[arr.widx] & arr.wdata;
                end
                FBEP_AC_ERASE: begin
                    mem[arr.widx] <= FBEP_ERASED;
                end
                default: begin
                end
            endcase
        end
    end
endmodule

// *** logic/fbep_gate.sv ***

`timescale 1ns/1ps
module fbep_gate
    import fbep_pkg::*;
(
    input wire logic clk,                        // System clock, 100 MHz
    input wire logic rst,                        // Async reset, active high
    input wire logic ce,                         // Clock enable, freezes state
    input wire logic [FBEP_UNITS-1:0] prot_ro,   // Per-unit read-only marks
    input wire logic [FBEP_UNITS-1:0] prot_xo,   // Per-unit execute-only marks
    input wire logic req_valid,                  // Request offered
    input wire fbep_src_e req_src,               // Fetch, data or debugger
    input wire fbep_op_e req_op,                 // Read, program or erase
    input wire logic [FBEP_ADDR_W-1:0] req_addr, // Byte address in the array
    input wire logic [FBEP_DATA_W-1:0] req_wdata,// Program data
    output logic req_ready,                      // Gate idle, takes request
    output logic rsp_valid,                      // One-cycle answer pulse
    output logic rsp_err,                        // Request refused
    output logic [FBEP_DATA_W-1:0] rsp_rdata     // Read data, zero on error
);
    // Reads take two cycles because the array registers its output
    typedef enum {
        ST_IDLE,
        ST_READ,
        ST_RRESP,
        ST_PROG,
        ST_ERASE
    } fbep_state_e;

    fbep_state_e state_reg;
    fbep_acmd_e acmd_reg;
    logic [FBEP_WIDX_W-1:0] widx_reg;
    logic [FBEP_DATA_W-1:0] wdata_reg;
    // Erase walk: block number and word offset inside it
    logic [FBEP_BLK_W-1:0] blk_reg;
    logic [FBEP_WOFF_W-1:0] woff_reg;
    logic accept;
    logic deny;
    logic [FBEP_UNIT_W-1:0] unit;

    fbep_arr_if arr ();

    // Array contents outlive rst; only an erase defines them
    fbep_array u_array (
        .clk (clk),
        .ce  (ce),
        .arr (arr.array)
    );

    assign arr.cmd = acmd_reg;
    assign arr.widx = widx_reg;
    assign arr.wdata = wdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Access decision

    // Both marks on one unit: execute-only wins as the stricter setting,
    // which falls out of checking each mark on its own
    function automatic logic fbep_denied(input logic ro, input logic xo,
                                         input fbep_op_e op,
                                         input fbep_src_e src);
        logic d;
        d = 1'b0;
        if (ro && op != FBEP_OP_READ) begin
            d = 1'b1;
        end
        if (xo && op != FBEP_OP_READ) begin
            d = 1'b1;
        end
        if (xo && op == FBEP_OP_READ && src != FBEP_SRC_FETCH) begin
            d = 1'b1;
        end
        return d;
    endfunction

    assign unit = req_addr[FBEP_UNIT_LSB +: FBEP_UNIT_W];
    assign accept = ce && req_valid && req_ready;
    // Decided in the accepting cycle so a refusal answers on the next edge
    assign deny = fbep_denied(prot_ro[unit], prot_xo[unit], req_op, req_src);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer and array commands

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            acmd_reg <= FBEP_AC_NONE;
            widx_reg <= '0;
            wdata_reg <= FBEP_ZERO;
            blk_reg <= '0;
            woff_reg <= '0;
        end else if (ce) begin
            case (state_reg)
                ST_IDLE: begin
                    acmd_reg <= FBEP_AC_NONE;
                    if (accept && !deny) begin
                        widx_reg <= req_addr[FBEP_WIDX_LSB +: FBEP_WIDX_W];
                        wdata_reg <= req_wdata;
                        blk_reg <= req_addr[FBEP_BLK_LSB +: FBEP_BLK_W];
                        woff_reg <= '0;
                        case (req_op)
                            FBEP_OP_READ: begin
                                acmd_reg <= FBEP_AC_READ;
                                state_reg <= ST_READ;
                            end
                            FBEP_OP_PROG: begin
                                acmd_reg <= FBEP_AC_PROG;
                                state_reg <= ST_PROG;
                            end
                            FBEP_OP_ERASE: begin
                                acmd_reg <= FBEP_AC_ERASE;
                                widx_reg <= {req_addr[FBEP_BLK_LSB +:
                                             FBEP_BLK_W], FBEP_WOFF_W'(0)};
                                state_reg <= ST_ERASE;
                            end
                            default: begin
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_READ: begin
                    acmd_reg <= FBEP_AC_NONE;
                    state_reg <= ST_RRESP;
                end
                ST_RRESP, ST_PROG: begin
                    acmd_reg <= FBEP_AC_NONE;
                    state_reg <= ST_IDLE;
                end
                ST_ERASE: begin
                    // One word per cycle; no request is taken until done
                    // whole block ones
                    if (woff_reg == FBEP_BLK_LAST) begin
                        acmd_reg <= FBEP_AC_NONE;
                        state_reg <= ST_IDLE;
                    end else begin
                        woff_reg <= woff_reg + 1'b1;
                        widx_reg <= {blk_reg, FBEP_WOFF_W'(woff_reg + 1'b1)};
                    end
                end
                default: begin
                    acmd_reg <= FBEP_AC_NONE;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready: drops on the accepting edge so only one operation is in flight
    // Refusals leave it high, so they may follow back to back

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_ready <= 1'b0;
        end else if (ce) begin
            if (state_reg == ST_IDLE) begin
                req_ready <= !(accept && !deny);
            end else if (state_reg == ST_ERASE) begin
                req_ready <= (woff_reg == FBEP_BLK_LAST);
            end else if (state_reg == ST_READ) begin
                req_ready <= 1'b0;
            end else begin
                req_ready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Answers
    // Error flag and data hold until the next answer; only valid pulses

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_err <= 1'b0;
            rsp_rdata <= FBEP_ZERO;
        end else if (ce) begin
            rsp_valid <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (accept && deny) begin
                        rsp_valid <= 1'b1;
                        rsp_err <= 1'b1;
                        rsp_rdata <= FBEP_ZERO;
                    end
                end
                ST_RRESP: begin
                    rsp_valid <= 1'b1;
                    rsp_err <= 1'b0;
                    rsp_rdata <= arr.rdata;
                end
                ST_PROG: begin
                    rsp_valid <= 1'b1;
                    rsp_err <= 1'b0;
                    rsp_rdata <= FBEP_ZERO;
                end
                ST_ERASE: begin
                    if (woff_reg == FBEP_BLK_LAST) begin
                        rsp_valid <= 1'b1;
                        rsp_err <= 1'b0;
                        rsp_rdata <= FBEP_ZERO;
                    end
                end
                default: begin
                end
            endcase
        end
    end
endmodule

// *** bench/fbep_gate_props.sv ***
`timescale 1ns/1ps
module fbep_gate_props
    import fbep_pkg::*;
(
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic ce, // enable
    input wire logic [FBEP_UNITS-1:0] prot_ro, // ro marks
    input wire logic [FBEP_UNITS-1:0] prot_xo, // xo marks
    input wire logic req_valid, // offer
    input wire fbep_src_e req_src, // source
    input wire fbep_op_e req_op, // operation
    input wire logic [FBEP_ADDR_W-1:0] req_addr, // address
    input wire logic req_ready, // idle
    input wire logic rsp_valid, // answer
    input wire logic rsp_err, // refused
    input wire logic [FBEP_DATA_W-1:0] rsp_rdata // read data
);
    logic acc;
    logic lk;
    logic rd_ok;
    assign acc = req_valid && req_ready && ce;
    assign lk = prot_ro[req_addr[14:11]] || prot_xo[req_addr[14:11]];
    assign rd_ok = req_op == FBEP_OP_READ && !(prot_xo[req_addr[14:11]]
        && req_src != FBEP_SRC_FETCH);
    // Frozen cycles would stretch every count, so they drop the attempt
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst || !ce);
    a_lock_refuse: assert property (acc && req_op != FBEP_OP_READ && lk
        |=> rsp_valid && rsp_err && req_ready) else $error("write not refused");
    a_xo_deny: assert property (acc && req_op == FBEP_OP_READ && !rd_ok
        |=> rsp_valid && rsp_err) else $error("hidden read not refused");
    a_err_blank: assert property (rsp_valid && rsp_err
        |-> rsp_rdata == FBEP_ZERO) else $error("refusal carries data");
    a_erase_time: assert property (acc && req_op == FBEP_OP_ERASE && !lk
        |=> !req_ready ##256 rsp_valid && !rsp_err) else $error("erase timing");
    a_prog_time: assert property (acc && req_op == FBEP_OP_PROG && !lk
        |=> !req_ready ##1 rsp_valid && !rsp_err) else $error("program timing");
    a_read_time: assert property (acc && rd_ok
        |=> !rsp_valid ##2 rsp_valid && !rsp_err) else $error("read timing");
    a_answer_ready: assert property (rsp_valid |-> req_ready)
        else $error("busy at answer");
    a_reset_quiet: assert property (disable iff (1'b0) rst
        |=> !req_ready && !rsp_valid) else $error("active in reset");
endmodule

// *** bench/fbep_req_model.sv ***
`timescale 1ns/1ps
module fbep_req_model
    import fbep_pkg::*;
(
    input wire logic clk, // clock
    input wire logic req_ready, // idle
    input wire logic rsp_valid, // answer
    input wire logic rsp_err, // refused
    input wire logic [FBEP_DATA_W-1:0] rsp_rdata, // read data
    output logic req_valid, // offer
    output fbep_src_e req_src, // source
    output fbep_op_e req_op, // operation
    output logic [FBEP_ADDR_W-1:0] req_addr, // address
    output logic [FBEP_DATA_W-1:0] req_wdata // program data
);
    int hung = 0;
    initial begin
        req_valid = 1'b0;
        req_src = FBEP_SRC_FETCH;
        req_op = FBEP_OP_READ;
        req_addr = 15'h7FFF;
        req_wdata = 32'hFFFFFFFF;
    end
    task automatic op(input fbep_src_e s, input fbep_op_e o,
            input logic [14:0] a, input logic [31:0] d,
            output logic e, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_src <= s;
        req_op <= o;
        req_addr <= a;
        req_wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (!req_ready && n < 20);
        if (!req_ready) hung++;
        // Released address and data lines show the inverse, never a stale copy; source and operation keep their last value
        req_valid <= 1'b0;
        req_addr <= ~a;
        req_wdata <= ~d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!rsp_valid && n < 300);
        if (!rsp_valid) hung++;
        e = rsp_err;
        r = rsp_rdata;
    endtask
endmodule

// *** bench/flash_block_erase_protect_test.sv ***
`timescale 1ns/1ps
module flash_block_erase_protect_test;
    import fbep_pkg::*;
    localparam fbep_src_e F = FBEP_SRC_FETCH;
    localparam fbep_src_e D = FBEP_SRC_DATA;
    localparam fbep_src_e G = FBEP_SRC_DEBUG;
    localparam fbep_op_e RD = FBEP_OP_READ;
    localparam fbep_op_e PG = FBEP_OP_PROG;
    localparam fbep_op_e ER = FBEP_OP_ERASE;
    localparam logic [31:0] PAT = 32'h5A5AA5A5;
    localparam logic [32:0] OK = {1'b0, FBEP_ZERO};
    localparam logic [32:0] NG = {1'b1, FBEP_ZERO};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [15:0] prot_ro = 16'h0000;
    logic [15:0] prot_xo = 16'h0000;
    logic req_valid, req_ready, rsp_valid, rsp_err;
    fbep_src_e req_src;
    fbep_op_e req_op;
    logic [14:0] req_addr;
    logic [31:0] req_wdata, rsp_rdata;
    int errors = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    fbep_gate i_fbep_gate (.clk(clk), .rst(rst), .ce(ce), .prot_ro(prot_ro),
        .prot_xo(prot_xo), .req_valid(req_valid), .req_src(req_src),
        .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
        .rsp_rdata(rsp_rdata));
    fbep_req_model i_fbep_req_model (.clk(clk), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_rdata(rsp_rdata),
        .req_valid(req_valid), .req_src(req_src), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata));
    task automatic chk(input string nm, input logic [32:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic go(input fbep_src_e s, input fbep_op_e o,
            input logic [14:0] a, input logic [31:0] d, input logic [32:0] x);
        logic e;
        logic [31:0] r;
        i_fbep_req_model.op(s, o, a, d, e, r);
        chk("answer", {e, r}, x);
        if (i_fbep_req_model.hung != 0) begin
            summarize;
        end
    endtask
    task automatic t_erase;
        go(D, ER, 15'h0800, 32'h0, OK);
        go(D, ER, 15'h0C00, 32'h0, OK);
        go(D, RD, 15'h0BFC, 32'h0, {1'b0, FBEP_ERASED});
        go(D, PG, 15'h0C04, PAT, OK);
        go(D, ER, 15'h0800, 32'h0, OK);
        go(D, RD, 15'h0C04, 32'h0, {1'b0, PAT});
        $display("test erase done");
    endtask
    task automatic t_ro;
        @(posedge clk);
        prot_ro <= 16'h0002;
        go(D, PG, 15'h0C04, 32'h0, NG);
        go(G, ER, 15'h0800, 32'h0, NG);
        go(G, RD, 15'h0C04, 32'h0, {1'b0, PAT});
        go(D, ER, 15'h0400, 32'h0, OK);
        go(F, RD, 15'h07FC, 32'h0, {1'b0, FBEP_ERASED});
        $display("test read-only done");
    endtask
    task automatic t_xo;
        @(posedge clk);
        prot_ro <= 16'h0000;
        prot_xo <= 16'h0002;
        go(D, ER, 15'h0C00, 32'h0, NG);
        go(G, PG, 15'h0C04, 32'h0, NG);
        go(D, RD, 15'h0C04, 32'h0, NG);
        go(G, RD, 15'h0C04, 32'h0, NG);
        go(F, RD, 15'h0C04, 32'h0, {1'b0, PAT});
        $display("test execute-only done");
    endtask
    task automatic t_free;
        @(posedge clk);
        prot_xo <= 16'h0000;
        go(G, PG, 15'h07FC, 32'h12345678, OK);
        go(G, RD, 15'h07FC, 32'h0, {1'b0, 32'h12345678});
        go(D, RD, 15'h0C04, 32'h0, {1'b0, PAT});
        $display("test unprotected done");
    endtask
    task automatic t_hold;
        fork
            go(D, ER, 15'h0400, 32'h0, OK);
            begin
                repeat (40) @(posedge clk);
                ce <= 1'b0;
                repeat (10) @(posedge clk);
                ce <= 1'b1;
            end
        join
        go(G, RD, 15'h07FC, 32'h0, {1'b0, FBEP_ERASED});
        $display("test clock enable done");
    endtask
    task automatic summarize;
        if (i_fbep_req_model.hung != 0) errors++;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_erase;
        t_ro;
        t_xo;
        t_free;
        t_hold;
        summarize;
    end
endmodule
bind fbep_gate fbep_gate_props i_fbep_gate_props (.clk(clk), .rst(rst),
    .ce(ce), .prot_ro(prot_ro), .prot_xo(prot_xo), .req_valid(req_valid),
    .req_src(req_src), .req_op(req_op), .req_addr(req_addr),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_rdata(rsp_rdata));
